//--- logic/pcdv_top.sv
// two-unit precision clock and frame sync generator with ahb-lite registers
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module pcdv_top
  import pcdv_pkg::*;
#(
  parameter int W = DIV_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic ref_osc_input,
  input wire logic [1:0] routed_source_input,
  input wire logic [1:0] ext_trigger_input,
  input wire logic oneshot_ref_a,
  input wire logic oneshot_ref_b,
  output logic [1:0] bit_clock_out,
  output logic [1:0] frame_sync_out
);
  logic [31:0] ctl0_reg [NUM_UNITS];
  logic [31:0] ctl1_reg [NUM_UNITS];
  logic [31:0] pw_reg;
  logic [31:0] sync_reg;
  logic [31:0] route_reg;
  logic [7:0] waddr_reg;
  logic wr_pend_reg;
  logic addr_ok;
  logic [31:0] status;
  logic [1:0] oneshot_ref;
  logic [1:0] ext_in;
  logic [1:0] run_clk;
  logic [1:0] run_fs;

  assign oneshot_ref = {oneshot_ref_b, oneshot_ref_a};
  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign addr_ok = hsel && hready &&
                   (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  ////////////////////////////////////////////////////////////////////////
  // feedback guard: selected codes tie each external input low
  assign ext_in[0] = (route_reg[ROUTE_FIELD_W-1:0] == ROUTE_LOW_A) ?
                     1'b0 : routed_source_input[0];
  assign ext_in[1] = (route_reg[2*ROUTE_FIELD_W-1:ROUTE_FIELD_W]
                      == ROUTE_LOW_B) ? 1'b0 : routed_source_input[1];

  ////////////////////////////////////////////////////////////////////////
  // address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      waddr_reg <= 8'h00;
    end else if (ce) begin
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok) begin
        waddr_reg <= haddr[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes in the data phase; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        ctl0_reg[u] <= CTL_RESET;
        ctl1_reg[u] <= CTL_RESET;
      end
      pw_reg <= PW_RESET;
      sync_reg <= SYNC_RESET;
      route_reg <= ROUTE_RESET;
    end else if (ce && wr_pend_reg) begin
      // no write protection: parameter changes on a live unit
      // take effect at once, glitches are software's concern
      case (waddr_reg)
        OFS_CTL_A0: ctl0_reg[0] <= hwdata;
        OFS_CTL_A1: ctl1_reg[0] <= hwdata;
        OFS_CTL_B0: ctl0_reg[1] <= hwdata;
        OFS_CTL_B1: ctl1_reg[1] <= hwdata;
        OFS_PW: pw_reg <= hwdata;
        OFS_SYNC: sync_reg <= hwdata;
        OFS_ROUTE: route_reg <= hwdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // live status word
  always_comb begin
    status = 32'h0000_0000;
    for (int u = 0; u < NUM_UNITS; u++) begin
      status[u*STAT_UNIT_STRIDE + 0] = bit_clock_out[u];
      status[u*STAT_UNIT_STRIDE + 1] = frame_sync_out[u];
      status[u*STAT_UNIT_STRIDE + 2] = run_clk[u];
      status[u*STAT_UNIT_STRIDE + 3] = run_fs[u];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data registered at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && addr_ok && !hwrite) begin
      case (haddr[7:0])
        OFS_CTL_A0: hrdata <= ctl0_reg[0];
        OFS_CTL_A1: hrdata <= ctl1_reg[0];
        OFS_CTL_B0: hrdata <= ctl0_reg[1];
        OFS_CTL_B1: hrdata <= ctl1_reg[1];
        OFS_PW: hrdata <= pw_reg;
        OFS_SYNC: hrdata <= sync_reg;
        OFS_ROUTE: hrdata <= route_reg;
        OFS_STATUS: hrdata <= status;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // the two units share nothing but the reference input
  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
    logic clk_sel;
    logic fs_sel;
    logic clk_prev_reg;
    logic fs_prev_reg;
    logic trig_prev_reg;
    logic os_prev_reg;
    logic trig_rise;
    logic fs_rise;
    logic fs_fall;
    logic os_rise;
    logic fs_en;
    logic fs_armed_reg;
    logic [W-1:0] fs_div;
    logic [W-1:0] phase;
    logic [PW_W-1:0] pw_val;
    logic [W-1:0] fs_width;
    logic [W-1:0] fcnt_reg;
    logic fs_out_reg;
    logic os_busy_reg;
    logic os_seen_reg;
    logic strobe;
    logic inv;

    // source selects: clear picks reference, set picks routed input
    assign clk_sel = ctl1_reg[u][CTL1_CLK_SRC] ? ext_in[u]
                                               : ref_osc_input;
    assign fs_sel = ctl1_reg[u][CTL1_FS_SRC] ? ext_in[u] : ref_osc_input;
    assign fs_div = ctl0_reg[u][W-1:0];
    assign phase = {ctl0_reg[u][PHASE_POS +: PHASE_HALF_W],
                    ctl1_reg[u][PHASE_POS +: PHASE_HALF_W]};
    assign pw_val = pw_reg[u*PW_UNIT_STRIDE +: PW_W];
    assign strobe = pw_reg[u*PW_UNIT_STRIDE + PW_STROBE];
    assign inv = pw_reg[u*PW_UNIT_STRIDE + PW_INV];
    assign fs_en = ctl0_reg[u][CTL0_FS_EN];
    assign fs_width = (pw_val == '0) ? (fs_div >> 1) : W'(pw_val);
    assign trig_rise = ext_trigger_input[u] && !trig_prev_reg;
    assign fs_rise = fs_sel && !fs_prev_reg;
    assign fs_fall = !fs_sel && fs_prev_reg;
    assign os_rise = oneshot_ref[u] && !os_prev_reg;
    assign run_fs[u] = fs_armed_reg;
    assign frame_sync_out[u] = fs_out_reg;

    // edge history of sampled inputs
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        clk_prev_reg <= 1'b0;
        fs_prev_reg <= 1'b0;
        trig_prev_reg <= 1'b0;
        os_prev_reg <= 1'b0;
      end else if (ce) begin
        clk_prev_reg <= clk_sel;
        fs_prev_reg <= fs_sel;
        trig_prev_reg <= ext_trigger_input[u];
        os_prev_reg <= oneshot_ref[u];
      end
    end

    pcdv_clkdiv #(
      .W(W)
    ) u_clkdiv (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .src_lvl(clk_sel),
      .src_rise(clk_sel && !clk_prev_reg),
      .enable(ctl0_reg[u][CTL0_CLK_EN]),
      .trig_en(sync_reg[u*SYNC_UNIT_STRIDE + SYNC_CLK_TRIG]),
      .trig_rise(trig_rise),
      .divisor(ctl1_reg[u][W-1:0]),
      .clk_out(bit_clock_out[u]),
      .running(run_clk[u])
    );

    // frame sync start gate, optional external trigger
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        fs_armed_reg <= 1'b0;
      end else if (ce) begin
        if (!fs_en) begin
          fs_armed_reg <= 1'b0;
        end else if (!sync_reg[u*SYNC_UNIT_STRIDE + SYNC_FS_TRIG] ||
                     trig_rise) begin
          fs_armed_reg <= 1'b1;
        end
      end
    end

    // frame sync: normal divider, direct bypass or one-shot
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        fcnt_reg <= '0;
        fs_out_reg <= 1'b0;
        os_busy_reg <= 1'b0;
        os_seen_reg <= 1'b0;
      end else if (ce) begin
        if (!fs_armed_reg) begin
          // preload so the first period starts after phase source rises
          fcnt_reg <= (phase == '0) ? '0 : fs_div - phase;
          fs_out_reg <= 1'b0;
          os_busy_reg <= 1'b0;
          os_seen_reg <= 1'b0;
        end else if (fs_div >= W'(2)) begin
          if (fs_rise) begin
            fs_out_reg <= (fcnt_reg < fs_width);
            fcnt_reg <= (fcnt_reg >= fs_div - W'(1)) ? '0
                        : fcnt_reg + W'(1);
          end
        end else if (!strobe) begin
          fs_out_reg <= fs_sel ^ inv;
        end else if (os_busy_reg) begin
          // pulse ends on the second rise of the one-shot reference
          if (os_rise) begin
            os_seen_reg <= 1'b1;
            if (os_seen_reg) begin
              os_busy_reg <= 1'b0;
              fs_out_reg <= 1'b0;
            end
          end
        end else if (inv ? fs_fall : fs_rise) begin
          os_busy_reg <= 1'b1;
          os_seen_reg <= 1'b0;
          fs_out_reg <= 1'b1;
        end
      end
    end
  end
endmodule

//--- logic/pcdv_clkdiv.sv
// package of constants and the bit clock divider used by each unit
package pcdv_pkg;
  localparam int NUM_UNITS = 2;
  localparam int DIV_W = 20;
  localparam int PW_W = 16;
  // register byte offsets
  localparam logic [7:0] OFS_CTL_A0 = 8'h00;
  localparam logic [7:0] OFS_CTL_A1 = 8'h04;
  localparam logic [7:0] OFS_CTL_B0 = 8'h08;
  localparam logic [7:0] OFS_CTL_B1 = 8'h0c;
  localparam logic [7:0] OFS_PW = 8'h10;
  localparam logic [7:0] OFS_SYNC = 8'h14;
  localparam logic [7:0] OFS_ROUTE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // first control register fields
  localparam int CTL0_CLK_EN = 31;
  localparam int CTL0_FS_EN = 30;
  // second control register fields
  localparam int CTL1_CLK_SRC = 31;
  localparam int CTL1_FS_SRC = 30;
  // phase halves sit in bits 29..20 of both control registers
  localparam int PHASE_POS = 20;
  localparam int PHASE_HALF_W = 10;
  // pulse width register: unit a low half, unit b high half
  localparam int PW_UNIT_STRIDE = 16;
  localparam int PW_STROBE = 0;
  localparam int PW_INV = 1;
  // sync register: per unit frame sync and clock trigger enables
  localparam int SYNC_UNIT_STRIDE = 16;
  localparam int SYNC_FS_TRIG = 0;
  localparam int SYNC_CLK_TRIG = 1;
  // routing select register
  localparam int ROUTE_FIELD_W = 5;
  localparam logic [4:0] ROUTE_LOW_A = 5'h1c;
  localparam logic [4:0] ROUTE_LOW_B = 5'h1d;
  // status register layout per unit
  localparam int STAT_UNIT_STRIDE = 8;
  // reset values
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] PW_RESET = 32'h0000_0000;
  localparam logic [31:0] SYNC_RESET = 32'h0000_0000;
  localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;
endpackage

`timescale 1ns/1ps

// bit clock divider: counts rising edges of the sampled source clock
module pcdv_clkdiv
  import pcdv_pkg::*;
#(
  parameter int W = DIV_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic src_lvl,
  input wire logic src_rise,
  input wire logic enable,
  input wire logic trig_en,
  input wire logic trig_rise,
  input wire logic [W-1:0] divisor,
  output logic clk_out,
  output logic running
);
  logic [W-1:0] cnt_reg;
  logic armed_reg;
  logic bypass;
  logic [W-1:0] high_len;

  // odd divisors: low phase gets the extra source period
  assign bypass = (divisor < W'(2));
  assign high_len = divisor >> 1;
  assign running = armed_reg;

  ////////////////////////////////////////////////////////////////////////
  // start gate: optional wait for a trigger rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_reg <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        armed_reg <= 1'b0;
      end else if (!trig_en || trig_rise) begin
        armed_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // divider counter and output, cleared while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      clk_out <= 1'b0;
    end else if (ce) begin
      if (!enable || !armed_reg) begin
        cnt_reg <= '0;
        clk_out <= 1'b0;
      end else if (bypass) begin
        clk_out <= src_lvl;
        cnt_reg <= '0;
      end else if (src_rise) begin
        // one output period spans divisor source periods
        clk_out <= (cnt_reg < high_len);
        cnt_reg <= (cnt_reg >= divisor - W'(1)) ? '0 : cnt_reg + W'(1);
      end
    end
  end
endmodule

//--- tb/pcdv_monitor.sv
// checker of bus answers and unit clock outputs of pcdv_top
`timescale 1ns/1ps
module pcdv_monitor
  import pcdv_pkg::*;
#(
  parameter int W = DIV_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ref_osc_input,
  input wire logic [1:0] routed_source_input,
  input wire logic [1:0] bit_clock_out
);
  logic wr_q, r1, oq, seen;
  logic [7:0] a_q;
  logic [31:0] a0, a1, b0;
  logic [19:0] nr;
  wire div_a = a0[31] && !a1[31] && a1[19:1] != 0;
  wire byp_a = a0[31] && a1[19:1] == 0;
  ////////////////////////////////////////
  // shadow control words, taken at the data phase edge like the design
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      a_q <= 8'h00;
      a0 <= CTL_RESET;
      a1 <= CTL_RESET;
      b0 <= CTL_RESET;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      a_q <= haddr[7:0];
      if (wr_q && a_q == OFS_CTL_A0) a0 <= hwdata;
      if (wr_q && a_q == OFS_CTL_A1) a1 <= hwdata;
      if (wr_q && a_q == OFS_CTL_B0) b0 <= hwdata;
    end
  end
  // source rises since the last change of unit a; offset cancels out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r1 <= 1'b0;
      oq <= 1'b0;
      seen <= 1'b0;
      nr <= 20'h00000;
    end else begin
      r1 <= ref_osc_input;
      oq <= bit_clock_out[0];
      if (!a0[31]) begin
        nr <= 20'h00000;
        seen <= 1'b0;
      end else if (oq != bit_clock_out[0]) begin
        nr <= {19'h00000, ref_osc_input && !r1};
        seen <= seen || oq;
      end else if (ref_osc_input && !r1) begin
        nr <= nr + 20'h00001;
      end
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_held(c);
    c ##3 c;
  endsequence
  property p_ready;
    hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_okay;
    hresp == HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_off_a;
    s_held(!a0[31]) |-> !bit_clock_out[0];
  endproperty
  a_off_a: assert property (p_off_a) else $error("a not low");
  property p_off_b;
    s_held(!b0[31]) |-> !bit_clock_out[1];
  endproperty
  a_off_b: assert property (p_off_b) else $error("b not low");
  property p_byp_ref;
    s_held(byp_a && !a1[31]) |-> bit_clock_out[0] == $past(ref_osc_input, 1);
  endproperty
  a_byp_ref: assert property (p_byp_ref) else $error("ref bypass");
  property p_byp_rt;
    s_held(byp_a && a1[31]) |->
      bit_clock_out[0] == $past(routed_source_input[0], 1);
  endproperty
  a_byp_rt: assert property (p_byp_rt) else $error("routed bypass");
  property p_high;
    div_a && oq && !bit_clock_out[0] |-> nr == {1'b0, a1[19:1]};
  endproperty
  a_high: assert property (p_high) else $error("high length");
  property p_low;
    div_a && seen && !oq && bit_clock_out[0] |->
      nr == a1[19:0] - {1'b0, a1[19:1]};
  endproperty
  a_low: assert property (p_low) else $error("low length");
endmodule

bind pcdv_top pcdv_monitor #(.W(W)) i_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .ref_osc_input(ref_osc_input),
  .routed_source_input(routed_source_input), .bit_clock_out(bit_clock_out)
);

//--- tb/pcdv_src_model.sv
// far side model: source clocks, trigger and one-shot references
`timescale 1ns/1ps
module pcdv_src_model (
  input wire logic hclk,
  input wire logic trig_go,
  output logic ref_osc_input,
  output logic [1:0] routed_source_input,
  output logic [1:0] ext_trigger_input,
  output logic oneshot_ref_a,
  output logic oneshot_ref_b
);
  int n = 0;
  ////////////////////////////////////////
  // edges land on the falling hclk edge, clear of the sampling edge
  always @(negedge hclk) begin
    n <= n + 1;
  end
  // periods 6, 10 and 4 hclk keep every source below hclk/2
  assign ref_osc_input = (n % 6) < 3;
  assign routed_source_input = {(n % 4) < 2, (n % 10) < 5};
  assign ext_trigger_input = {2{trig_go}};
  assign oneshot_ref_a = (n % 16) < 8;
  assign oneshot_ref_b = (n % 12) < 6;
endmodule

//--- tb/pcdv_top_tb_top.sv
// self-checking bench for the two-unit clock divider
`timescale 1ns/1ps
module pcdv_top_tb_top
  import pcdv_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, trig_go, ref_osc_input;
  logic hreadyout, hresp, oneshot_ref_a, oneshot_ref_b;
  logic [1:0] htrans, routed_source_input, ext_trigger_input;
  logic [1:0] bit_clock_out, frame_sync_out;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int errors = 0;
  int n_checks = 0;
  int hi, lo;
  logic fs_mode = 1'b0;
  // output under measurement: bit clocks, or frame syncs when fs_mode set
  wire [1:0] obs = fs_mode ? frame_sync_out : bit_clock_out;
  ////////////////////////////////////////
  // ce and hsize tied: bus is word only, no freeze tested
  pcdv_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .ref_osc_input(ref_osc_input),
    .routed_source_input(routed_source_input),
    .ext_trigger_input(ext_trigger_input), .oneshot_ref_a(oneshot_ref_a),
    .oneshot_ref_b(oneshot_ref_b), .bit_clock_out(bit_clock_out),
    .frame_sync_out(frame_sync_out)
  );
  pcdv_src_model i_src (
    .hclk(hclk), .trig_go(trig_go), .ref_osc_input(ref_osc_input),
    .routed_source_input(routed_source_input),
    .ext_trigger_input(ext_trigger_input), .oneshot_ref_a(oneshot_ref_a),
    .oneshot_ref_b(oneshot_ref_b)
  );
  ////////////////////////////////////////
  task automatic check(string s, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // one single word transfer; read data taken at the data phase edge
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // wait, at most 99 samples, until the watched output shows v
  task automatic wait_lvl(int u, logic v);
    for (int k = 0; k < 99 && obs[u] !== v; k++) begin
      @(negedge hclk);
    end
  endtask
  // one high and one low phase of unit u; the first high after enable
  // may be cut short in bypass, so a whole period is skipped first
  task automatic measure(int u);
    hi = 0;
    lo = 0;
    wait_lvl(u, 1'b1);
    wait_lvl(u, 1'b0);
    wait_lvl(u, 1'b1);
    while (hi < 99 && obs[u] === 1'b1) begin
      hi++;
      @(negedge hclk);
    end
    while (lo < 99 && obs[u] === 1'b0) begin
      lo++;
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask
  // counts samples that are not low; unknown counts against a quiet output
  // one edge is let pass first: a disable lands one cycle after its write
  task automatic watch(int u, int n);
    hi = 0;
    @(posedge hclk);
    repeat (n) begin
      @(negedge hclk);
      if (obs[u] !== 1'b0) hi++;
    end
    @(posedge hclk);
  endtask
  task automatic t_regs();
    logic [31:0] pat [9] = '{32'h3fff_ffff, 32'h3fff_ffff, 32'h3ffa_5a5a,
      32'h2005_0005, 32'hffff_ffff, 32'h0003_0003, 32'h0000_03a5,
      32'hffff_ffff, 32'hffff_ffff};
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      check("reset value", rd, 32'h0);
      bus(1'b1, 8'(i * 4), pat[i]);
    end
    // status and the unmapped word must not keep what was written
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      check("read back", rd, i < 7 ? pat[i] : 32'h0);
      bus(1'b1, 8'(i * 4), 32'h0);
    end
    $display("register test done");
  endtask
  task automatic t_clock();
    logic [31:0] dv [8] = '{32'h0, 32'h1, 32'h8000_0000, 32'h2, 32'h4,
      32'h5, 32'h7, 32'h8000_0003};
    int eh [8] = '{3, 3, 5, 6, 12, 12, 18, 10};
    int el [8] = '{3, 3, 5, 6, 12, 18, 24, 20};
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, OFS_CTL_A0, 32'h0);
      repeat (8) @(posedge hclk);
      bus(1'b1, OFS_CTL_A1, dv[i]);
      bus(1'b1, OFS_CTL_A0, 32'h8000_0000);
      measure(0);
      check("high time", hi, eh[i]);
      check("low time", lo, el[i]);
      check("b idle", 32'(bit_clock_out[1]), 32'h0);
    end
    bus(1'b1, OFS_CTL_A0, 32'h0);
    watch(0, 10);
    check("a disabled", hi, 0);
    $display("clock test done");
  endtask
  // frame sync of unit a from the reference: divide by four, then bypass
  task automatic t_fsync();
    fs_mode = 1'b1;
    bus(1'b1, OFS_CTL_A0, 32'h4000_0004);
    measure(0);
    check("fs high", hi, 12);
    check("fs low", lo, 12);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("fs running", 32'(rd[3]), 32'h1);
    bus(1'b1, OFS_CTL_A0, 32'h0);
    repeat (8) @(posedge hclk);
    bus(1'b1, OFS_CTL_A0, 32'h4000_0000);
    measure(0);
    check("fs bypass high", hi, 3);
    check("fs bypass low", lo, 3);
    bus(1'b1, OFS_CTL_A0, 32'h0);
    fs_mode = 1'b0;
    $display("frame sync test done");
  endtask
  task automatic t_route();
    bus(1'b1, OFS_ROUTE, 32'h0000_03a0);
    bus(1'b1, OFS_CTL_B1, 32'h8000_0000);
    bus(1'b1, OFS_CTL_B0, 32'h8000_0000);
    watch(1, 24);
    check("tied input", hi, 0);
    bus(1'b1, OFS_CTL_B0, 32'h0);
    bus(1'b1, OFS_ROUTE, 32'h0);
    bus(1'b1, OFS_CTL_B0, 32'h8000_0000);
    measure(1);
    check("b high", hi, 2);
    check("b low", lo, 2);
    bus(1'b1, OFS_CTL_B0, 32'h0);
    $display("routing test done");
  endtask
  task automatic t_trig();
    repeat (8) @(posedge hclk);
    bus(1'b1, OFS_SYNC, 32'h0002_0000);
    bus(1'b1, OFS_CTL_B1, 32'h0000_0002);
    bus(1'b1, OFS_CTL_B0, 32'h8000_0000);
    watch(1, 40);
    check("before trigger", hi, 0);
    trig_go <= 1'b1;
    watch(1, 40);
    check("after trigger", 32'(hi > 10), 32'h1);
    $display("trigger test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // reset for five cycles, then the tests in turn
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    trig_go = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_clock();
    t_fsync();
    t_route();
    t_trig();
    print_verdict();
  end
  // hang guard, well past the thousand or so cycles the tests need
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
endmodule
